// *** hw/atsc_pkg.sv ***
// Shared constants for the converter trigger and status block.
// Assumes a 40 MHz core clock and an AXI4-Lite register bus.
package atsc_pkg;
  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int NPAIR = 6;
  localparam int PIDX_W = 3;
  localparam int SRC_W = 6;
  localparam int RES_W = 10;
  localparam int ADDR_W = 8;
  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ISTAT = 8'h08;
  localparam logic [7:0] OFF_IMASK = 8'h0C;
  localparam logic [7:0] OFF_PAIR = 8'h10;
  localparam logic [7:0] OFF_RES = 8'h30;
  // ----------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------
  localparam int CTRL_GST = 0;
  localparam int CTRL_ORDER = 1;
  localparam int CTRL_SEQ = 2;
  localparam int PC_SOFT = 6;
  localparam int PC_IRQEN = 7;
  localparam int PC_PEND = 8;
  localparam logic [5:0] SRC_INDIV_SW = 6'h01;
  localparam logic [5:0] SRC_GLOBAL_SW = 6'h0C;
  localparam int SHARED_LO = 8;
  localparam int SHARED_HI = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int MAX_RATE_SPS = 1_500_000;
  localparam int GAP_CYC = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  localparam int GAP_W = 5;
  // Register select
  typedef enum logic [2:0] {
    REG_CTRL, REG_STAT, REG_ISTAT, REG_IMASK, REG_PAIR, REG_RES, REG_NONE
  } atsc_reg_t;
endpackage : atsc_pkg

// *** hw/atsc_rate.sv ***
// Spacing counter that holds off conversion starts.
// Assumes one start pulse per conversion on the same clock.
`timescale 1ns/10ps
module atsc_rate (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  output logic ok
);
  logic [atsc_pkg::GAP_W-1:0] cnt_r;

  // Reload on start, count down to zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_r <= atsc_pkg::GAP_W'(atsc_pkg::GAP_CYC - 1);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign ok = (cnt_r == '0);
endmodule : atsc_rate

// *** hw/atsc_pick.sv ***
// Round-robin choice among pairs with an open request.
// Assumes last holds the most recently served pair.
`timescale 1ns/10ps
module atsc_pick (
  input wire logic [atsc_pkg::NPAIR-1:0] req,
  input wire logic [atsc_pkg::PIDX_W-1:0] last,
  output logic hit,
  output logic [atsc_pkg::PIDX_W-1:0] sel
);
  // Scan backwards so the pair nearest after last wins
  always_comb begin
    int idx;
    idx = 0;
    hit = 1'b0;
    sel = '0;
    for (int k = atsc_pkg::NPAIR; k >= 1; k--) begin
      idx = (int'(last) + k) % atsc_pkg::NPAIR;
      if (req[idx]) begin
        hit = 1'b1;
        sel = atsc_pkg::PIDX_W'(idx);
      end
    end
  end
endmodule : atsc_pick

// *** hw/atsc_ctrl.sv ***
// Converter trigger, ready/pending flags and interrupt logic.
// Assumes an AXI4-Lite master and a converter on ref_clk.
//
// Functional notes
// - Global trigger starts every pair whose source selects it.
// - Finished conversion sets that pair's ready flag.
// - Clearing ready flags also clears the global trigger bit.
// - Re-setting global trigger skips pairs still showing ready.
// - Source 0x01 lets a pair's own soft bit start it alone.
// - Pending flag per pair shows its soft conversion in flight.
// - No new interrupt while ready set; handler clears ready.
// - Pair interrupt enable routes completion to global interrupt when its mask bit is set.
// - Conversion starts spaced to at most 1.5 Msps.
// - Odd inputs and inputs 8 to 11 use the shared hold.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module atsc_ctrl (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic conv_start,
  output logic [2:0] conv_pair,
  output logic [1:0] conv_shared,
  output logic conv_order,
  output logic conv_seq_samp,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  output logic irq
);
  localparam int N = atsc_pkg::NPAIR;

  // ----------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------
  function automatic atsc_pkg::atsc_reg_t dec(input logic [7:0] a);
    dec = atsc_pkg::REG_NONE;
    if (a[1:0] == 2'h0) begin
      if (a == atsc_pkg::OFF_CTRL) dec = atsc_pkg::REG_CTRL;
      else if (a == atsc_pkg::OFF_STAT) dec = atsc_pkg::REG_STAT;
      else if (a == atsc_pkg::OFF_ISTAT) dec = atsc_pkg::REG_ISTAT;
      else if (a == atsc_pkg::OFF_IMASK) dec = atsc_pkg::REG_IMASK;
      else if (a >= atsc_pkg::OFF_PAIR &&
               a < atsc_pkg::OFF_PAIR + 8'h18)
        dec = atsc_pkg::REG_PAIR;
      else if (a >= atsc_pkg::OFF_RES &&
               a < atsc_pkg::OFF_RES + 8'h18)
        dec = atsc_pkg::REG_RES;
    end
  endfunction : dec

  function automatic logic [2:0] pidx(input logic [7:0] a,
                                      input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    pidx = d[4:2];
  endfunction : pidx

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction : merge

  // Input index sits on the shared sample-and-hold
  function automatic logic shared_in(input int idx);
    shared_in = (idx % 2 == 1) ||
                (idx >= atsc_pkg::SHARED_LO &&
                 idx <= atsc_pkg::SHARED_HI);
  endfunction : shared_in

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [7:0] waddr_r;
  logic [3:0] wstrb_r;
  logic gst_r, order_r, seq_r, irq_r;
  logic [N-1:0] ready_r, istat_r, imask_r, soft_r, irqen_r;
  logic [N-1:0] pend_r, req_r;
  logic [5:0] src_r [N];
  logic [9:0] res_r [N];
  logic busy_r, conv_start_r;
  logic [2:0] cur_r, conv_pair_r;
  logic [1:0] conv_shared_r;

  logic wr_go, rd_go, wr_ctrl, wr_stat, wr_imask, rd_istat;
  logic gst_fire, done_fire, issue, pick_hit, rate_ok;
  logic [2:0] pick_sel, wpair;
  logic [31:0] ctrl_new, pc_new, rd_val, wmask;
  logic [1:0] rd_resp;
  logic [N-1:0] glob_sel, gst_set, sw_hit, sw_src, rdy_clr;
  logic [N-1:0] done_vec, ev_vec, wr_pair;
  atsc_pkg::atsc_reg_t wsel, rsel;

  // ----------------------------------------------------------
  // Write and read path decode
  // ----------------------------------------------------------
  assign wsel = dec(waddr_r);
  assign rsel = dec(s_axi_araddr);
  assign wpair = pidx(waddr_r, atsc_pkg::OFF_PAIR);
  assign wr_go = ce && !awready_r && !wready_r && !bvalid_r;
  assign rd_go = ce && s_axi_arvalid && arready_r;
  assign wr_ctrl = wr_go && wsel == atsc_pkg::REG_CTRL;
  assign wr_stat = wr_go && wsel == atsc_pkg::REG_STAT;
  assign wr_imask = wr_go && wsel == atsc_pkg::REG_IMASK;
  assign rd_istat = rd_go && rsel == atsc_pkg::REG_ISTAT;
  assign ctrl_new = merge({29'h0, seq_r, order_r, gst_r},
                          wdata_r, wstrb_r);
  assign pc_new = merge({24'h0, irqen_r[wpair], soft_r[wpair],
                         src_r[wpair]}, wdata_r, wstrb_r);
  // Strobed write data alone, for write-one-to-clear and mask writes
  assign wmask = merge('0, wdata_r, wstrb_r);
  assign rdy_clr = wr_stat ? wmask[N-1:0] : '0;

  // Per-pair trigger qualifiers
  always_comb begin
    for (int p = 0; p < N; p++) begin
      glob_sel[p] = src_r[p] == atsc_pkg::SRC_GLOBAL_SW;
      sw_src[p] = glob_sel[p] || src_r[p] == atsc_pkg::SRC_INDIV_SW;
      wr_pair[p] = wr_go && wsel == atsc_pkg::REG_PAIR &&
                   wpair == 3'(p);
      sw_hit[p] = wr_pair[p] && pc_new[atsc_pkg::PC_SOFT] &&
                  pc_new[5:0] == atsc_pkg::SRC_INDIV_SW;
    end
  end

  // Global trigger fires only on a fresh set of the bit
  assign gst_fire = wr_ctrl && ctrl_new[atsc_pkg::CTRL_GST] && !gst_r;
  assign done_fire = ce && busy_r && conv_done;
  assign done_vec = done_fire ? N'(1) << cur_r : '0;
  assign gst_set = gst_fire ?
                   (glob_sel & ~ready_r & ~done_vec) : '0;
  assign ev_vec = done_vec & ~ready_r & irqen_r;

  // ----------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= atsc_pkg::RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wsel == atsc_pkg::REG_NONE) ?
                   atsc_pkg::RESP_SLVERR : atsc_pkg::RESP_OKAY;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_resp = atsc_pkg::RESP_OKAY;
    unique case (rsel)
      atsc_pkg::REG_CTRL: rd_val = {29'h0, seq_r, order_r, gst_r};
      atsc_pkg::REG_STAT: rd_val = {26'h0, ready_r};
      atsc_pkg::REG_ISTAT: rd_val = {26'h0, istat_r};
      atsc_pkg::REG_IMASK: rd_val = {26'h0, imask_r};
      atsc_pkg::REG_PAIR: begin
        rd_val = {23'h0, pend_r[pidx(s_axi_araddr, atsc_pkg::OFF_PAIR)],
                  irqen_r[pidx(s_axi_araddr, atsc_pkg::OFF_PAIR)],
                  soft_r[pidx(s_axi_araddr, atsc_pkg::OFF_PAIR)],
                  src_r[pidx(s_axi_araddr, atsc_pkg::OFF_PAIR)]};
      end
      atsc_pkg::REG_RES: begin
        rd_val = {22'h0, res_r[pidx(s_axi_araddr, atsc_pkg::OFF_RES)]};
      end
      atsc_pkg::REG_NONE: rd_resp = atsc_pkg::RESP_SLVERR;
    endcase
  end

  // Capture read data one cycle after the address
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= atsc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_resp;
      end else if (rvalid_r && s_axi_rready) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Control register
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gst_r <= 1'b0;
      order_r <= 1'b0;
      seq_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        gst_r <= ctrl_new[atsc_pkg::CTRL_GST];
        order_r <= ctrl_new[atsc_pkg::CTRL_ORDER];
        seq_r <= ctrl_new[atsc_pkg::CTRL_SEQ];
      end
      if (|rdy_clr) gst_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Pair flags, requests and results
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r <= '0;
      req_r <= '0;
      pend_r <= '0;
      soft_r <= '0;
      irqen_r <= '0;
      for (int p = 0; p < N; p++) begin
        src_r[p] <= '0;
        res_r[p] <= '0;
      end
    end else if (ce) begin
      ready_r <= (ready_r & ~rdy_clr) | done_vec;
      req_r <= (req_r & ~done_vec) | gst_set | sw_hit;
      pend_r <= (pend_r & ~done_vec) | sw_hit;
      soft_r <= (soft_r & ~done_vec) | sw_hit;
      for (int p = 0; p < N; p++) begin
        if (wr_pair[p]) begin
          src_r[p] <= pc_new[5:0];
          irqen_r[p] <= pc_new[atsc_pkg::PC_IRQEN];
        end
        if (done_vec[p]) res_r[p] <= conv_result;
      end
    end
  end

  // ----------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      istat_r <= (rd_istat ? '0 : istat_r) | ev_vec;
      if (wr_imask) imask_r <= wmask[N-1:0];
      irq_r <= |(istat_r & imask_r);
    end
  end

  // ----------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------
  atsc_pick u_pick (
    .req(req_r),
    .last(cur_r),
    .hit(pick_hit),
    .sel(pick_sel)
  );

  atsc_rate u_rate (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(issue),
    .ok(rate_ok)
  );

  assign issue = ce && !busy_r && pick_hit && rate_ok;

  // Start one pair at a time and wait for its result
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      cur_r <= '0;
      conv_start_r <= 1'b0;
      conv_pair_r <= '0;
      conv_shared_r <= '0;
    end else if (ce) begin
      conv_start_r <= issue;
      if (issue) begin
        busy_r <= 1'b1;
        cur_r <= pick_sel;
        conv_pair_r <= pick_sel;
        conv_shared_r <= {shared_in(2 * int'(pick_sel) + 1),
                          shared_in(2 * int'(pick_sel))};
      end else if (done_fire) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign conv_start = conv_start_r;
  assign conv_pair = conv_pair_r;
  assign conv_shared = conv_shared_r;
  assign conv_order = order_r;
  assign conv_seq_samp = seq_r;
  assign irq = irq_r;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  logic [5:0] since_r;

  // Cycles since the last conversion start
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_r <= 6'h3F;
    end else if (ce) begin
      if (issue) since_r <= '0;
      else if (since_r != 6'h3F) since_r <= since_r + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  glob_start_a: assert property (gst_fire |=>
    (req_r & $past(gst_set)) == $past(gst_set))
    else $error("global trigger missed a pair");
  ready_set_a: assert property (done_fire |=>
    ready_r[$past(cur_r)])
    else $error("ready flag not set on completion");
  gst_clear_a: assert property (ce && |rdy_clr |=> !gst_r)
    else $error("global trigger bit not cleared");
  no_retrig_a: assert property (gst_fire |=>
    (req_r & ~$past(req_r) & $past(ready_r)) == '0)
    else $error("pair with ready flag retriggered");
  indiv_a: assert property (ce && |sw_hit |=>
    (req_r & pend_r & $past(sw_hit)) == $past(sw_hit))
    else $error("individual trigger not taken");
  pend_req_a: assert property ((pend_r & ~req_r) == '0)
    else $error("pending flag without request");
  irq_hold_a: assert property (done_fire && ready_r[cur_r] &&
    !rd_istat |=> istat_r == $past(istat_r))
    else $error("interrupt raised while ready set");
  irq_route_a: assert property (done_fire && irqen_r[cur_r] &&
    !ready_r[cur_r] && imask_r[cur_r] ##1 ce |-> ##1 irq_r)
    else $error("enabled completion gave no interrupt");
  rate_gap_a: assert property (issue |->
    since_r >= 6'(atsc_pkg::GAP_CYC - 1))
    else $error("conversion starts too close");
  shared_a: assert property (conv_start_r |->
    conv_shared_r == {1'b1, conv_pair_r >= 3'h4})
    else $error("shared hold flag wrong");
  other_src_a: assert property (wr_go |=>
    (req_r & ~$past(req_r) & ~$past(sw_src | sw_hit)) == '0)
    else $error("non software pair triggered");

  glob_c: cover property (gst_fire ##[1:200] done_fire);
  indiv_c: cover property (|sw_hit ##[1:200] done_fire);
  irq_c: cover property ($rose(irq_r));
  clear_c: cover property (|rdy_clr && gst_r);
endmodule : atsc_ctrl

// *** tb/tb_adc_trigger_status_control.sv ***
// Self-checking bench for the converter trigger and status block.
// Assumes the block's AXI4-Lite slave; a converter is modelled here.
`timescale 1ns/10ps
module tb_adc_trigger_status_control;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  localparam int MIN_GAP = (40_000_000 + 1_499_999) / 1_500_000;
  localparam int DLY = 10;
  logic ref_clk, arst_n, ce;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, conv_shared;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq;
  logic conv_start, conv_order, conv_seq_samp, conv_done;
  logic [2:0] conv_pair;
  logic [9:0] conv_result;
  int num_errors, checks;
  int starts [6];

  atsc_ctrl DUT (.ref_clk, .arst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_pair,
    .conv_shared, .conv_order, .conv_seq_samp, .conv_done,
    .conv_result, .irq);

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
        exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er = 2'h0);
    int n = 0;
    logic done = 1'h0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        chk(32'(s_axi_bresp), 32'(er), "write resp");
        s_axi_bready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) chk(32'h0, 32'h1, "write hang");
  endtask : wr

  // Bus read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
      input logic [1:0] er = 2'h0);
    int n = 0;
    logic done = 1'h0;
    v = 32'h0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        v = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(er), "read resp");
        s_axi_rready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) chk(32'h0, 32'h1, "read hang");
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, e, "read value");
  endtask : rc

  // Polls a register field until it shows the wanted value
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] v;
    int n = 0;
    v = ~e;
    while ((v & m) !== e && n < 60) begin
      rd(a, v);
      n++;
    end
    chk(v & m, e, "poll value");
  endtask : poll

  task automatic cs(input int e [6]);
    for (int i = 0; i < 6; i++) chk(32'(starts[i]), 32'(e[i]), "starts");
  endtask : cs

  task automatic wirq;
    int n = 0;
    while (irq !== 1'h1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(irq), 32'h1, "irq raise");
  endtask : wirq

  // ----------------------------------------------------------
  // Clock, converter stand-in and watchdog
  // ----------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Answers each start DLY cycles later and checks start spacing
  initial begin
    int since, cnt;
    logic [2:0] p;
    since = 1000;
    cnt = 0;
    p = 3'h0;
    conv_done = 1'h0;
    conv_result = 10'h0;
    forever begin
      @(posedge ref_clk);
      since++;
      if (cnt == 1) begin
        conv_done <= 1'h1;
        conv_result <= 10'h2A0 + 10'(p);
      end else conv_done <= 1'h0;
      if (cnt > 0) cnt--;
      if (conv_start === 1'h1) begin
        p = conv_pair;
        starts[p]++;
        chk(32'(since >= MIN_GAP), 32'h1, "spacing");
        chk(32'(conv_shared), 32'h2 | 32'(p >= 3'h4), "hold");
        since = 0;
        cnt = DLY;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    chk(32'h0, 32'h1, "watchdog");
    wrap_up;
  end

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    logic [5:0] src [6];
    src = '{6'h0C, 6'h0C, 6'h01, 6'h05, 6'h0C, 6'h05};
    num_errors = 0;
    checks = 0;
    arst_n = 1'h0;
    ce = 1'h1;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'h1;
    // Reset values, unmapped and read-only places
    for (int i = 0; i < 5; i++) rc(8'(4 * i), 32'hFFFFFFFF, 32'h0);
    chk(32'(irq), 32'h0, "irq idle");
    rd(8'h48, d, 2'h2);
    chk(d, 32'h0, "unmapped data");
    rd(8'h28, d, 2'h2);
    chk(d, 32'h0, "missing pair data");
    wr(8'h02, 32'h1, 2'h2);
    wr(8'h30, 32'h3FF);
    rc(8'h30, 32'hFFFFFFFF, 32'h0);
    // Converter mode and pair sources
    wr(8'h00, 32'h2);
    chk(32'({conv_order, conv_seq_samp}), 32'h2, "order bit");
    wr(8'h00, 32'h4);
    chk(32'({conv_order, conv_seq_samp}), 32'h1, "mode");
    for (int i = 0; i < 6; i++) wr(8'h10 + 8'(4 * i), 32'(src[i]));
    // Global trigger, then re-trigger while ready still set
    wr(8'h00, 32'h5);
    poll(8'h04, 32'h3F, 32'h13);
    cs('{1, 1, 0, 0, 1, 0});
    rc(8'h40, 32'h3FF, 32'h2A4);
    rc(8'h08, 32'h3F, 32'h0);
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h5);
    repeat (100) @(posedge ref_clk);
    cs('{1, 1, 0, 0, 1, 0});
    wr(8'h04, 32'h3F);
    rc(8'h00, 32'h7, 32'h4);
    rc(8'h04, 32'h3F, 32'h0);
    wr(8'h00, 32'h5);
    poll(8'h04, 32'h3F, 32'h13);
    cs('{2, 2, 0, 0, 2, 0});
    // Individual trigger and pending flag
    wr(8'h04, 32'h3F);
    wr(8'h18, 32'h41);
    rc(8'h18, 32'h100, 32'h100);
    poll(8'h18, 32'h100, 32'h0);
    cs('{2, 2, 1, 0, 2, 0});
    rc(8'h04, 32'h3F, 32'h4);
    wr(8'h1C, 32'h45);
    rc(8'h1C, 32'h1FF, 32'h5);
    repeat (60) @(posedge ref_clk);
    cs('{2, 2, 1, 0, 2, 0});
    // Interrupt raise, clear, hold-off while ready and mask
    wr(8'h04, 32'h3F);
    // Freeze with ce low between the take and the response
    fork
      begin
        repeat (2) @(posedge ref_clk);
        ce <= 1'h0;
        repeat (20) @(posedge ref_clk);
        chk(32'(s_axi_bvalid), 32'h0, "frozen write");
        ce <= 1'h1;
      end
      wr(8'h0C, 32'h4);
    join
    wr(8'h18, 32'hC1);
    wirq;
    rc(8'h08, 32'h3F, 32'h4);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0, "irq clear");
    wr(8'h18, 32'hC1);
    poll(8'h18, 32'h100, 32'h0);
    repeat (3) @(posedge ref_clk);
    rc(8'h08, 32'h3F, 32'h0);
    chk(32'(irq), 32'h0, "irq held off");
    wr(8'h04, 32'h4);
    wr(8'h18, 32'hC1);
    wirq;
    rc(8'h08, 32'h3F, 32'h4);
    wr(8'h04, 32'h3F);
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'hC1);
    poll(8'h18, 32'h100, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(32'(irq), 32'h0, "irq masked");
    rc(8'h08, 32'h3F, 32'h4);
    wrap_up;
  end
endmodule : tb_adc_trigger_status_control
